//--- rtl/cfs_cfg.svh
// Opcode values, field positions and widths for the compare and flag skip unit
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

`define CFS_WORD_W      10
`define CFS_NIB_W       4
`define CFS_CTRL_W      4
`define CFS_OP_IMM      10'h025
`define CFS_OP_IMM_HI   6'h07
`define CFS_OP_MEM      10'h026
`define CFS_OP_EXT0     10'h038
`define CFS_OP_EXT1     10'h039
`define CFS_EN0_BIT     0
`define CFS_EN1_BIT     1
`define CFS_IMM_LSB     0
`define CFS_IMM_MSB     3

`endif

//--- rtl/cfs_pkg.sv
// Types shared by the compare and flag skip unit
`default_nettype none
`include "cfs_cfg.svh"

package cfs_pkg;

    typedef enum logic [1:0] {
        CFS_FETCH,
        CFS_IMM_WAIT,
        CFS_DROP_IMM
    } cfs_state_t;

    typedef struct packed {
        logic                    valid;
        logic [`CFS_WORD_W-1:0]  word;
    } cfs_fetch_t;

    typedef struct packed {
        logic [`CFS_NIB_W-1:0]   acc;
        logic [`CFS_NIB_W-1:0]   mem;
    } cfs_operands_t;

    typedef struct packed {
        logic                    ext0_request_flag;
        logic                    ext1_request_flag;
    } cfs_req_flags_t;

    typedef struct packed {
        logic                    ext0_clear;
        logic                    ext1_clear;
    } cfs_flag_clear_t;

endpackage : cfs_pkg
`default_nettype wire

//--- rtl/cfs_skip_unit.sv
// Decode and execute of the compare and interrupt flag skip instructions
// What this block does
// RULE1 - Immediate compare is two words, two cycles; second word low nibble is immediate
// RULE2 - Immediate compare skips next instruction when accumulator equals immediate 0..15
// RULE3 - Memory compare is one word; skips when accumulator equals addressed memory nibble
// RULE4 - Memory compare with unequal operands lets next instruction execute
// RULE5 - External-0 test skips when its request flag is set and enable is clear
// RULE6 - External-0 test clears its flag after skipping; flag untouched otherwise
// RULE7 - External-0 enable is control bit 0; when set, the test is a no-operation
// RULE8 - External-1 test skips when its request flag is set and enable is clear
// RULE9 - External-1 test clears its flag after skipping; flag untouched otherwise
// RULE10 - External-1 enable is control bit 1; when set, the test is a no-operation
// RULE11 - No carry or accumulator change; skipped instruction is fetched, not executed
`timescale 1ns/10ps
`default_nettype none
`include "cfs_cfg.svh"

module cfs_skip_unit #(
    parameter int WORD_W = `CFS_WORD_W,
    parameter int NIB_W  = `CFS_NIB_W
) (
    input  wire logic                       clock_in,
    input  wire logic                       nrst_in,
    input  wire logic                       ce_in,
    input  wire cfs_pkg::cfs_fetch_t        fetch_in,
    input  wire cfs_pkg::cfs_operands_t     operands_in,
    input  wire logic [`CFS_CTRL_W-1:0]     irq_control_one_in,
    input  wire cfs_pkg::cfs_req_flags_t    flags_in,
    output logic                            execute_out,
    output logic                            discard_out,
    output logic                            skip_pending_out,
    output logic                            imm_wait_out,
    output var cfs_pkg::cfs_flag_clear_t    flag_clear_out,
    output logic                            acc_write_out,
    output logic                            carry_write_out
);
    import cfs_pkg::*;

    // Opcodes are fixed ten-bit codes, so no other word or data width can decode them
    if (WORD_W != `CFS_WORD_W || NIB_W != `CFS_NIB_W) begin : g_bad_widths
        $error("cfs_skip_unit: opcode constants only serve 10-bit words and 4-bit data");
    end

    function automatic logic op_is(input logic [`CFS_WORD_W-1:0] word,
                                   input logic [`CFS_WORD_W-1:0] code);
        op_is = (word == code);
    endfunction : op_is

    cfs_state_t               state_q;
    cfs_state_t               state_d;
    logic                     skip_q;
    logic                     skip_d;
    cfs_flag_clear_t          clear_q;
    cfs_flag_clear_t          clear_d;

    wire logic                take      = ce_in & fetch_in.valid;
    wire logic [NIB_W-1:0]    imm_val   = fetch_in.word[`CFS_IMM_MSB:`CFS_IMM_LSB];
    wire logic                en0       = irq_control_one_in[`CFS_EN0_BIT];   // [RULE7]
    wire logic                en1       = irq_control_one_in[`CFS_EN1_BIT];   // [RULE10]
    wire logic                in_fetch  = (state_q == CFS_FETCH);
    // A word met while a skip is pending is fetched but not executed
    wire logic                drop_word = (in_fetch & skip_q) | (state_q == CFS_DROP_IMM);
    wire logic                exec_word = in_fetch & ~skip_q;

    wire logic                dec_imm   = op_is(fetch_in.word, `CFS_OP_IMM);
    wire logic                dec_mem   = op_is(fetch_in.word, `CFS_OP_MEM);
    wire logic                dec_ext0  = op_is(fetch_in.word, `CFS_OP_EXT0);
    wire logic                dec_ext1  = op_is(fetch_in.word, `CFS_OP_EXT1);

    wire logic                imm_hit   = (operands_in.acc == imm_val);          // [RULE2]
    wire logic                mem_hit   = (operands_in.acc == operands_in.mem);  // [RULE3] [RULE4]
    // Enable set turns the flag tests into no-operations
    wire logic                ext0_hit  = ~en0 & flags_in.ext0_request_flag;     // [RULE5] [RULE7]
    wire logic                ext1_hit  = ~en1 & flags_in.ext1_request_flag;     // [RULE8] [RULE10]

    assign execute_out      = fetch_in.valid & exec_word;
    assign discard_out      = fetch_in.valid & drop_word;                        // [RULE11]
    assign skip_pending_out = skip_q;
    assign imm_wait_out     = (state_q == CFS_IMM_WAIT);
    assign flag_clear_out   = clear_q;
    // These instructions only compare; result lands in skip, never in accumulator or carry
    assign acc_write_out    = 1'b0;                                              // [RULE11]
    assign carry_write_out  = 1'b0;                                              // [RULE11]

    always_comb begin
        state_d = state_q;
        skip_d  = skip_q;
        clear_d = '0;
        if (take) begin
            unique case (state_q)
                CFS_FETCH: begin
                    skip_d = 1'b0;
                    if (skip_q) begin
                        // Skipping a two-word compare must also drop its immediate word
                        if (dec_imm) begin
                            state_d = CFS_DROP_IMM;                              // [RULE11]
                        end
                    end else if (dec_imm) begin
                        state_d = CFS_IMM_WAIT;                                  // [RULE1]
                    end else if (dec_mem) begin
                        skip_d = mem_hit;                                        // [RULE3] [RULE4]
                    end else if (dec_ext0) begin
                        skip_d             = ext0_hit;                           // [RULE5]
                        clear_d.ext0_clear = ext0_hit;                           // [RULE6]
                    end else if (dec_ext1) begin
                        skip_d             = ext1_hit;                           // [RULE8]
                        clear_d.ext1_clear = ext1_hit;                           // [RULE9]
                    end
                end
                CFS_IMM_WAIT: begin
                    skip_d  = imm_hit;                                           // [RULE1] [RULE2]
                    state_d = CFS_FETCH;
                end
                CFS_DROP_IMM: begin
                    skip_d  = 1'b0;
                    state_d = CFS_FETCH;
                end
            endcase
        end else if (ce_in) begin
            clear_d = '0;
        end else begin
            clear_d = clear_q;
        end
    end

    // Clock enable low holds every flop, including the clear pulses
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_q <= CFS_FETCH;
            skip_q  <= 1'b0;
            clear_q <= '0;
        end else if (ce_in) begin
            state_q <= state_d;
            skip_q  <= skip_d;
            clear_q <= clear_d;
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    sequence s_imm_first;
        ce_in && fetch_in.valid && execute_out && fetch_in.word == `CFS_OP_IMM;
    endsequence

    sequence s_imm_second_eq;
        ce_in && fetch_in.valid && imm_wait_out && operands_in.acc == fetch_in.word[3:0];
    endsequence

    sequence s_ext0_take;
        ce_in && fetch_in.valid && execute_out && fetch_in.word == `CFS_OP_EXT0;
    endsequence

    sequence s_ext1_take;
        ce_in && fetch_in.valid && execute_out && fetch_in.word == `CFS_OP_EXT1;
    endsequence

    chk_imm_two_words: assert property (                                         // [RULE1]
        s_imm_first |=> imm_wait_out && !skip_pending_out)
        else $error("immediate compare did not wait for its second word");

    chk_imm_equal_skip: assert property (                                        // [RULE2]
        s_imm_second_eq |=> skip_pending_out && !imm_wait_out)
        else $error("immediate compare match did not raise skip");

    chk_imm_unequal_run: assert property (                                       // [RULE2]
        (ce_in && fetch_in.valid && imm_wait_out
         && operands_in.acc != fetch_in.word[3:0]) |=> !skip_pending_out)
        else $error("immediate compare mismatch raised skip");

    chk_mem_cmp_skip: assert property (                                          // [RULE3]
        (ce_in && fetch_in.valid && execute_out && fetch_in.word == `CFS_OP_MEM)
        |=> skip_pending_out == $past(mem_hit))
        else $error("memory compare skip does not follow the comparison");

    chk_mem_cmp_unequal: assert property (                                       // [RULE4]
        (ce_in && fetch_in.valid && execute_out && fetch_in.word == `CFS_OP_MEM
         && operands_in.acc != operands_in.mem) |=> !skip_pending_out)
        else $error("memory compare mismatch raised skip");

    chk_ext0_skip_clear: assert property (                                       // [RULE5] [RULE6]
        (s_ext0_take ##0 (!irq_control_one_in[0] && flags_in.ext0_request_flag))
        |=> skip_pending_out && flag_clear_out.ext0_clear)
        else $error("external-0 test missed skip or clear");

    chk_ext0_nop_enabled: assert property (                                      // [RULE7]
        (s_ext0_take ##0 irq_control_one_in[0])
        |=> !skip_pending_out && !flag_clear_out.ext0_clear)
        else $error("external-0 test acted while its enable was set");

    chk_ext0_flag_idle: assert property (                                        // [RULE6]
        (s_ext0_take ##0 !flags_in.ext0_request_flag)
        |=> !skip_pending_out && !flag_clear_out.ext0_clear)
        else $error("external-0 test skipped or cleared with its flag low");

    chk_ext1_skip_clear: assert property (                                       // [RULE8] [RULE9]
        (s_ext1_take ##0 (!irq_control_one_in[1] && flags_in.ext1_request_flag))
        |=> skip_pending_out && flag_clear_out.ext1_clear)
        else $error("external-1 test missed skip or clear");

    chk_ext1_nop_enabled: assert property (                                      // [RULE10]
        (s_ext1_take ##0 (irq_control_one_in[1] || !flags_in.ext1_request_flag))
        |=> !skip_pending_out && !flag_clear_out.ext1_clear)
        else $error("external-1 test skipped or cleared without cause");

    chk_clear_only_skip: assert property (                                       // [RULE6]
        $rose(flag_clear_out.ext0_clear) |-> $rose(skip_pending_out))
        else $error("external-0 flag cleared without a skip");

    chk_skip_drops_word: assert property (                                       // [RULE11]
        (skip_pending_out && fetch_in.valid && !imm_wait_out) |-> discard_out && !execute_out)
        else $error("skipped word was executed");

    chk_skip_dbl_word: assert property (                                         // [RULE11]
        (ce_in && fetch_in.valid && discard_out && skip_pending_out
         && fetch_in.word == `CFS_OP_IMM)
        ##1 (ce_in && fetch_in.valid) |-> discard_out ##1 !discard_out[*1])
        else $error("immediate word of a skipped compare was not dropped");

    chk_imm_not_exec: assert property (                                          // [RULE1]
        (imm_wait_out && fetch_in.valid) |-> !execute_out && !discard_out)
        else $error("immediate word was treated as an instruction");

    chk_no_acc_carry: assert property (                                          // [RULE11]
        !acc_write_out && !carry_write_out)
        else $error("compare instruction wrote accumulator or carry");

endmodule : cfs_skip_unit
`default_nettype wire

//--- verification/test_cfs_skip_unit.sv
// Self-checking testbench for the compare and flag skip unit
`timescale 1ns/10ps
`default_nettype none
`include "cfs_cfg.svh"

module test_cfs_skip_unit;
    import cfs_pkg::*;

    logic                    clock_in;
    logic                    nrst_in;
    logic                    ce_in;
    cfs_fetch_t              fetch_in;
    cfs_operands_t           operands_in;
    logic [`CFS_CTRL_W-1:0]  irq_control_one_in;
    cfs_req_flags_t          flags_in;
    // Staged operand values, applied with the next word so all inputs move at one offset
    cfs_operands_t           ops_nx;
    logic [`CFS_CTRL_W-1:0]  ctrl_nx;
    cfs_req_flags_t          flags_nx;
    logic                    execute_out;
    logic                    discard_out;
    logic                    skip_pending_out;
    logic                    imm_wait_out;
    cfs_flag_clear_t         flag_clear_out;
    logic                    acc_write_out;
    logic                    carry_write_out;
    int                      fails = 0;
    int                      n_checks = 0;

    cfs_skip_unit cfs_skip_unit_inst (
        .clock_in           (clock_in),
        .nrst_in            (nrst_in),
        .ce_in              (ce_in),
        .fetch_in           (fetch_in),
        .operands_in        (operands_in),
        .irq_control_one_in (irq_control_one_in),
        .flags_in           (flags_in),
        .execute_out        (execute_out),
        .discard_out        (discard_out),
        .skip_pending_out   (skip_pending_out),
        .imm_wait_out       (imm_wait_out),
        .flag_clear_out     (flag_clear_out),
        .acc_write_out      (acc_write_out),
        .carry_write_out    (carry_write_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Word goes up just after the edge; the extra step lets combinational outputs settle
    task automatic issue(input logic [9:0] w);
        @(posedge clock_in);
        #1;
        fetch_in.valid = 1'b1;
        fetch_in.word = w;
        operands_in = ops_nx;
        irq_control_one_in = ctrl_nx;
        flags_in = flags_nx;
        #1;
        chk({9'h000, acc_write_out | carry_write_out}, 10'h000);
    endtask : issue

    task automatic t_imm;
        for (int n = 0; n < 16; n++) begin
            for (int d = 0; d < 2; d++) begin
                ops_nx.acc = 4'(n + d);
                issue(`CFS_OP_IMM);
                issue({`CFS_OP_IMM_HI, 4'(n)});
                chk(imm_wait_out, 1'b1);
                chk(execute_out, 1'b0);
                issue(10'h000);
                chk(imm_wait_out, 1'b0);
                chk(skip_pending_out, d == 0);
                chk(discard_out, d == 0);
                chk(execute_out, d != 0);
            end
        end
        $display("test immediate compare finished");
    endtask : t_imm

    task automatic t_mem;
        for (int v = 0; v < 16; v++) begin
            for (int d = 0; d < 2; d++) begin
                ops_nx.acc = 4'(v);
                ops_nx.mem = 4'(v) ^ 4'(d * 4);
                issue(`CFS_OP_MEM);
                issue(10'h000);
                chk(skip_pending_out, d == 0);
                chk(discard_out, d == 0);
            end
        end
        $display("test memory compare finished");
    endtask : t_mem

    // The other enable bit is driven opposite and the other flag is held set to catch a crossed select
    task automatic t_ext(input logic which);
        logic s;
        for (int c = 0; c < 4; c++) begin
            s = (c == 1);
            ctrl_nx = c[1] ? (which ? 4'h2 : 4'h1) : (which ? 4'h1 : 4'h2);
            flags_nx.ext0_request_flag = which ? 1'b1 : c[0];
            flags_nx.ext1_request_flag = which ? c[0] : 1'b1;
            issue(which ? `CFS_OP_EXT1 : `CFS_OP_EXT0);
            issue(10'h000);
            chk(skip_pending_out, s);
            chk(flag_clear_out, which ? {1'b0, s} : {s, 1'b0});
            issue(10'h000);
            chk(flag_clear_out, 2'b00);
        end
        $display("test flag skip finished");
    endtask : t_ext

    // A skipped two-word compare must drop its immediate word as well
    task automatic t_drop;
        ops_nx.acc = 4'h9;
        ops_nx.mem = 4'h9;
        issue(`CFS_OP_MEM);
        issue(`CFS_OP_IMM);
        chk(discard_out, 1'b1);
        issue({`CFS_OP_IMM_HI, 4'h9});
        chk(discard_out, 1'b1);
        chk(imm_wait_out, 1'b0);
        issue(10'h000);
        chk(skip_pending_out, 1'b0);
        chk(execute_out, 1'b1);
        issue(`CFS_OP_MEM);
        @(posedge clock_in);
        #1;
        ce_in = 1'b0;
        fetch_in.word = 10'h000;
        @(posedge clock_in);
        #1;
        ce_in = 1'b1;
        fetch_in.valid = 1'b0;
        chk(skip_pending_out, 1'b1);
        issue(10'h000);
        chk(skip_pending_out, 1'b1);
        chk(discard_out, 1'b1);
        $display("test dropped pair and freeze finished");
    endtask : t_drop

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        #(3000 * 100);
        fails++;
        tally_and_finish();
    end

    initial begin
        nrst_in = 1'b0;
        ce_in = 1'b1;
        fetch_in = '0;
        operands_in = '0;
        irq_control_one_in = 4'h0;
        flags_in = '0;
        ops_nx = '0;
        ctrl_nx = 4'h0;
        flags_nx = '0;
        repeat (2) @(posedge clock_in);
        #1;
        nrst_in = 1'b1;
        chk({skip_pending_out, imm_wait_out, flag_clear_out}, 10'h000);
        t_imm();
        t_mem();
        t_ext(1'b0);
        t_ext(1'b1);
        t_drop();
        tally_and_finish();
    end
endmodule : test_cfs_skip_unit
`default_nettype wire
